// File: verilog/lcd_pkg.sv
// Purpose: Shared constants and types for the segment LCD driver control
// Assumes: 8-bit data memory, registers selected by a small index
// Notes: All register reset values are zero
package lcd_pkg;
    // ****************************************
    // Display memory map
    // ****************************************
    localparam logic [7:0] DISP_SECTOR = 8'h04;
    localparam logic [7:0] GP_SECTOR = 8'h00;
    localparam int SMALL_WORDS = 32;
    localparam int LARGE_WORDS = 46;
    // ****************************************
    // Register selects, masks and resets
    // ****************************************
    localparam logic [1:0] SEL_MAIN = 2'h0;
    localparam logic [1:0] SEL_PUMP = 2'h1;
    localparam logic [1:0] SEL_DUTY = 2'h2;
    localparam logic [7:0] MAIN_MASK = 8'hF7;
    localparam logic [7:0] PUMP_MASK = 8'h0B;
    localparam logic [7:0] DUTY_MASK = 8'hE7;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int MAIN_TYPE_BIT = 7;
    localparam int MAIN_RCT_BIT = 6;
    localparam int MAIN_SRC_LSB = 4;
    localparam int MAIN_CUR_LSB = 1;
    localparam int MAIN_EN_BIT = 0;
    localparam int PUMP_PR_BIT = 3;
    localparam int PUMP_VS_LSB = 0;
    localparam int DUTY_PCK_LSB = 5;
    localparam int DUTY_DTY_LSB = 1;
    localparam int DUTY_BIAS_BIT = 0;
    // ****************************************
    // Codes and timing
    // ****************************************
    localparam logic [1:0] DUTY_4 = 2'h0;
    localparam logic [1:0] DUTY_6 = 2'h1;
    localparam logic [1:0] DUTY_8 = 2'h2;
    localparam logic [2:0] PCK_DIV2 = 3'h6;
    localparam logic [2:0] PCK_TOP = 3'h6;
    localparam logic [2:0] LCD_DIV_LAST = 3'h7;
    localparam logic [7:0] MASK_4 = 8'h0F;
    localparam logic [7:0] MASK_6 = 8'h3F;
    localparam logic [7:0] MASK_8 = 8'hFF;
    localparam logic [2:0] COM_LAST_4 = 3'h3;
    localparam logic [2:0] COM_LAST_6 = 3'h5;
    localparam logic [2:0] COM_LAST_8 = 3'h7;
    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic wave_b;
        logic cap_bias;
        logic [1:0] cap_src;
        logic [1:0] bias_cur;
        logic res_pump_on;
        logic [1:0] pump_volt;
        logic quarter_bias;
        logic [1:0] duty;
    } analog_cfg_type;
    typedef struct packed {
        logic [7:0] sector;
        logic [7:0] offset;
        logic indirect;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mem_req_type;
endpackage

// File: verilog/lcd_driver_control.sv
// Purpose: Display memory, control registers, clocking and scan of a segment LCD driver
// Assumes: Subclock oscillators arrive as pins, sleep is a level from the power controller
// Notes: Analog bias, pumps and waveform shaping sit outside; this block gives their controls
// Notes on behaviour
// RQ1: Display memory spans offsets 00H up to last word of sector 4.
// RQ2: Software loads 04H into a pointer high byte, then uses its low byte.
// RQ3: Direct access to display offsets lands in sector 0 general memory.
// RQ4: Display memory is read and written only by indirect access.
// RQ5: Stored one lights an element; new data is used at once.
// RQ6: Bits without a common behind them are not stored and read zero.
// RQ7: LCD clock is the subclock divided by eight.
// RQ8: Subclock comes from RC or crystal oscillator per source select.
// RQ9: Pump clock is the subclock divided by the three-bit divider field.
// RQ10: Codes 000 to 101 divide by 128 down to 4; 110, 111 by 2.
// RQ11: Enable acts only awake; sleep forces the display off.
// RQ12: Disabled or asleep holds the driver in reset with outputs low.
// RQ13: Main bit 7 picks waveform type A or B.
// RQ14: Main bit 6 picks resistor or capacitor bias with pump on.
// RQ15: Main bits 5 and 4 pick the capacitor bias source.
// RQ16: Main bits 2 and 1 pick the resistor bias current.
// RQ17: Software keeps current bits 00 under capacitor bias.
// RQ18: Main bit 0 enables the driver.
// RQ19: Power select bit picks supply pin or internal pump for resistor bias.
// RQ20: Software keeps power select zero under capacitor bias.
// RQ21: Pump voltage bits set internal pump output for resistor bias.
// RQ22: Duty code picks 1/4, 1/6, 1/8; bias bit picks 1/3 or 1/4.
// RQ23: Scan steps commons on the LCD clock, fetching their memory bits.
`timescale 1ns/1ps
module lcd_driver_control #(
    parameter int DISP_WORDS = lcd_pkg::LARGE_WORDS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Subclock and power state
    input wire logic i_low_speed_rc_osc_clk,
    input wire logic i_lxt_clk,
    input wire logic i_subclk_src_select,
    input wire logic i_sleep,
    // Data memory access
    input wire lcd_pkg::mem_req_type i_mem_req,
    output logic [7:0] o_mem_rdata_q,
    output logic o_disp_hit_q,
    output logic o_gp_redirect_q,
    // Control register access
    input wire logic [1:0] i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata_q,
    // Panel drive
    output logic [7:0] o_com_q,
    output logic [DISP_WORDS-1:0] o_seg_q,
    output logic o_polarity_q,
    output logic o_lcd_tick_q,
    output logic o_pump_clk_q,
    output lcd_pkg::analog_cfg_type o_cfg_q
);
    localparam int AW = $clog2(DISP_WORDS);
    localparam logic [7:0] LAST_OFF = 8'(DISP_WORDS - 1);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [7:0] com_mask(input logic [1:0] duty);
        unique case (duty)
            lcd_pkg::DUTY_6: com_mask = lcd_pkg::MASK_6;
            lcd_pkg::DUTY_8: com_mask = lcd_pkg::MASK_8;
            default: com_mask = lcd_pkg::MASK_4;
        endcase
    endfunction

    function automatic logic [2:0] com_last(input logic [1:0] duty);
        unique case (duty)
            lcd_pkg::DUTY_6: com_last = lcd_pkg::COM_LAST_6;
            lcd_pkg::DUTY_8: com_last = lcd_pkg::COM_LAST_8;
            default: com_last = lcd_pkg::COM_LAST_4;
        endcase
    endfunction

    function automatic logic [2:0] pump_tap(input logic [2:0] code);
        if (code >= lcd_pkg::PCK_DIV2) begin
            pump_tap = 3'h0; // [RQ10]
        end else begin
            pump_tap = lcd_pkg::PCK_TOP - code; // [RQ10]
        end
    endfunction

    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] main_display_control_q;
    logic [7:0] pump_power_control_q;
    logic [7:0] duty_bias_control_q;
    logic run;
    logic [1:0] duty;
    logic [7:0] active_mask;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            main_display_control_q <= lcd_pkg::REG_RESET;
            pump_power_control_q <= lcd_pkg::REG_RESET;
            duty_bias_control_q <= lcd_pkg::REG_RESET;
        end else if (i_reg_wr) begin
            if (i_reg_sel == lcd_pkg::SEL_MAIN) begin
                main_display_control_q <= i_reg_wdata & lcd_pkg::MAIN_MASK;
            end
            if (i_reg_sel == lcd_pkg::SEL_PUMP) begin
                pump_power_control_q <= i_reg_wdata & lcd_pkg::PUMP_MASK;
            end
            if (i_reg_sel == lcd_pkg::SEL_DUTY) begin
                duty_bias_control_q <= i_reg_wdata & lcd_pkg::DUTY_MASK;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_reg_rdata_q <= lcd_pkg::REG_RESET;
        end else if (i_reg_rd) begin
            unique case (i_reg_sel)
                lcd_pkg::SEL_MAIN: o_reg_rdata_q <= main_display_control_q;
                lcd_pkg::SEL_PUMP: o_reg_rdata_q <= pump_power_control_q;
                lcd_pkg::SEL_DUTY: o_reg_rdata_q <= duty_bias_control_q;
                default: o_reg_rdata_q <= lcd_pkg::REG_RESET;
            endcase
        end
    end

    // Sleep overrides the enable bit
    assign run = main_display_control_q[lcd_pkg::MAIN_EN_BIT] & ~i_sleep; // [RQ11] [RQ12] [RQ18]
    assign duty = duty_bias_control_q[lcd_pkg::DUTY_DTY_LSB +: 2];
    assign active_mask = com_mask(duty); // [RQ22]

    // ****************************************
    // Analog controls
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_cfg_q <= '0;
        end else begin
            o_cfg_q.wave_b <= main_display_control_q[lcd_pkg::MAIN_TYPE_BIT]; // [RQ13]
            o_cfg_q.cap_bias <= main_display_control_q[lcd_pkg::MAIN_RCT_BIT] & run; // [RQ14]
            o_cfg_q.cap_src <= main_display_control_q[lcd_pkg::MAIN_SRC_LSB +: 2]; // [RQ15]
            o_cfg_q.bias_cur <= main_display_control_q[lcd_pkg::MAIN_CUR_LSB +: 2]; // [RQ16]
            // Internal pump only for resistor bias while running
            o_cfg_q.res_pump_on <= pump_power_control_q[lcd_pkg::PUMP_PR_BIT]
                & ~main_display_control_q[lcd_pkg::MAIN_RCT_BIT] & run; // [RQ19]
            o_cfg_q.pump_volt <= pump_power_control_q[lcd_pkg::PUMP_VS_LSB +: 2]; // [RQ21]
            o_cfg_q.quarter_bias <= duty_bias_control_q[lcd_pkg::DUTY_BIAS_BIT]; // [RQ22]
            o_cfg_q.duty <= duty; // [RQ22]
        end
    end

    // ****************************************
    // Subclock selection and dividers
    // ****************************************
    logic [2:0] low_speed_rc_osc_sync_q;
    logic [2:0] lxt_sync_q;
    logic sub_tick;
    logic [2:0] lcd_div_q;
    logic [6:0] pump_cnt_q;
    logic lcd_tick;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            low_speed_rc_osc_sync_q <= 3'h0;
            lxt_sync_q <= 3'h0;
        end else begin
            low_speed_rc_osc_sync_q <= {low_speed_rc_osc_sync_q[1:0], i_low_speed_rc_osc_clk};
            lxt_sync_q <= {lxt_sync_q[1:0], i_lxt_clk};
        end
    end

    // Only the settled stages feed the edge detector
    assign sub_tick = i_subclk_src_select ? (lxt_sync_q[1] & ~lxt_sync_q[2])
                                          : (low_speed_rc_osc_sync_q[1] & ~low_speed_rc_osc_sync_q[2]); // [RQ8]
    assign lcd_tick = sub_tick && (lcd_div_q == lcd_pkg::LCD_DIV_LAST);

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !run) begin
            lcd_div_q <= 3'h0;
        end else if (sub_tick) begin
            lcd_div_q <= lcd_div_q + 3'h1; // [RQ7]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !run) begin
            pump_cnt_q <= 7'h00;
        end else if (sub_tick) begin
            pump_cnt_q <= pump_cnt_q + 7'h01; // [RQ9]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_pump_clk_q <= 1'b0;
            o_lcd_tick_q <= 1'b0;
        end else begin
            // Pump clock runs only for capacitor bias
            o_pump_clk_q <= pump_cnt_q[pump_tap(duty_bias_control_q[lcd_pkg::DUTY_PCK_LSB +: 3])]
                & main_display_control_q[lcd_pkg::MAIN_RCT_BIT] & run; // [RQ9] [RQ14]
            o_lcd_tick_q <= lcd_tick; // [RQ7]
        end
    end

    // ****************************************
    // Display memory
    // ****************************************
    logic [7:0] disp_mem_q [DISP_WORDS];
    logic in_disp;
    logic disp_access;
    logic [AW-1:0] word_idx;

    assign in_disp = (i_mem_req.sector == lcd_pkg::DISP_SECTOR) && (i_mem_req.offset <= LAST_OFF); // [RQ1]
    assign disp_access = in_disp && i_mem_req.indirect; // [RQ2] [RQ4]
    assign word_idx = i_mem_req.offset[AW-1:0];

    // Missing commons are masked on write; bits stored under a longer duty stay until rewritten
    always_ff @(posedge i_mclk) begin
        if (disp_access && i_mem_req.wr) begin
            disp_mem_q[word_idx] <= i_mem_req.wdata & active_mask; // [RQ6]
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_mem_rdata_q <= 8'h00;
            o_disp_hit_q <= 1'b0;
            o_gp_redirect_q <= 1'b0;
        end else begin
            o_disp_hit_q <= disp_access && (i_mem_req.wr || i_mem_req.rd); // [RQ4]
            // Direct access to a display offset goes to sector 0 instead
            o_gp_redirect_q <= in_disp && !i_mem_req.indirect
                && (i_mem_req.wr || i_mem_req.rd); // [RQ3]
            if (disp_access && i_mem_req.rd) begin
                o_mem_rdata_q <= disp_mem_q[word_idx] & active_mask; // [RQ6]
            end
        end
    end

    // ****************************************
    // Common scan
    // ****************************************
    logic [2:0] com_idx_q;
    logic half_q;
    logic frame_pol_q;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !run) begin
            com_idx_q <= 3'h0; // [RQ12]
            half_q <= 1'b0;
            frame_pol_q <= 1'b0;
        end else if (lcd_tick) begin
            if (o_cfg_q.wave_b) begin
                // Type B flips polarity once per frame
                half_q <= 1'b0;
                if (com_idx_q >= com_last(duty)) begin
                    com_idx_q <= 3'h0; // [RQ23]
                    frame_pol_q <= ~frame_pol_q; // [RQ13]
                end else begin
                    com_idx_q <= com_idx_q + 3'h1; // [RQ23]
                end
            end else begin
                // Type A flips polarity inside each common slot
                half_q <= ~half_q; // [RQ13]
                frame_pol_q <= 1'b0;
                if (half_q) begin
                    if (com_idx_q >= com_last(duty)) begin
                        com_idx_q <= 3'h0; // [RQ23]
                    end else begin
                        com_idx_q <= com_idx_q + 3'h1; // [RQ23]
                    end
                end
            end
        end
    end

    // Segments follow memory every cycle, so writes show at once
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !run) begin
            o_com_q <= 8'h00; // [RQ12]
            o_seg_q <= '0; // [RQ12]
            o_polarity_q <= 1'b0;
        end else begin
            o_com_q <= 8'(1 << com_idx_q) & active_mask; // [RQ23]
            for (int i = 0; i < DISP_WORDS; i++) begin
                o_seg_q[i] <= disp_mem_q[i][com_idx_q]; // [RQ5] [RQ23]
            end
            o_polarity_q <= half_q ^ frame_pol_q;
        end
    end
endmodule // lcd_driver_control

// File: testbench/lcd_driver_control_monitor.sv
// Purpose: Port checker for the LCD driver control
// Assumes: One clock, synchronous active-high reset
// Notes: Duty lag guarded so a fresh duty write cannot trip the mask check
`timescale 1ns/1ps
module lcd_driver_control_monitor #(
    parameter int DISP_WORDS = 46
) (
    // Clock, reset and inputs
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_sleep,
    input wire lcd_pkg::mem_req_type i_mem_req,
    input wire logic i_reg_wr,
    // Outputs watched
    input wire logic [7:0] o_mem_rdata_q,
    input wire logic o_disp_hit_q,
    input wire logic o_gp_redirect_q,
    input wire logic [7:0] o_com_q,
    input wire logic [DISP_WORDS-1:0] o_seg_q,
    input wire logic o_lcd_tick_q,
    input wire logic o_pump_clk_q,
    input wire lcd_pkg::analog_cfg_type o_cfg_q
);
    // ****************************************
    // Assertions
    // ****************************************
    logic acc;
    assign acc = (i_mem_req.wr | i_mem_req.rd) && i_mem_req.sector == lcd_pkg::DISP_SECTOR
        && i_mem_req.offset < DISP_WORDS;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    AST_DISP_HIT: assert property (acc && i_mem_req.indirect |=> o_disp_hit_q && !o_gp_redirect_q)
        else $error("display access not claimed");
    AST_DIRECT_REDIR: assert property (acc && !i_mem_req.indirect |=> o_gp_redirect_q && !o_disp_hit_q)
        else $error("direct access not redirected");
    AST_OUT_RANGE: assert property ((i_mem_req.wr | i_mem_req.rd) && !acc |=> !o_disp_hit_q)
        else $error("access outside display claimed");
    AST_SLEEP_OFF: assert property (i_sleep |=> o_com_q == 8'h00)
        else $error("common driven while asleep");
    AST_STOP_LOW: assert property (o_com_q == 8'h00 |-> o_seg_q == '0)
        else $error("segments driven while stopped");
    AST_ONE_COMMON: assert property ($onehot0(o_com_q))
        else $error("more than one common active");
    AST_TICK_GAP: assert property (o_lcd_tick_q |=> !o_lcd_tick_q [*8])
        else $error("LCD ticks too close");
    AST_PUMP_IDLE: assert property (!o_cfg_q.cap_bias [*2] |-> !o_pump_clk_q)
        else $error("pump clock without capacitor bias");
    AST_RES_PUMP: assert property (o_cfg_q.res_pump_on |-> !o_cfg_q.cap_bias)
        else $error("resistor pump on under capacitor bias");
    AST_READ_MASK: assert property (acc && i_mem_req.indirect && i_mem_req.rd && !i_reg_wr && !$past(i_reg_wr)
        && o_cfg_q.duty == lcd_pkg::DUTY_4 |=> o_mem_rdata_q[7:4] == 4'h0)
        else $error("unbacked bits read nonzero");
endmodule // lcd_driver_control_monitor
bind lcd_driver_control lcd_driver_control_monitor #(.DISP_WORDS(DISP_WORDS)) i_mon (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_sleep(i_sleep), .i_mem_req(i_mem_req), .i_reg_wr(i_reg_wr),
    .o_mem_rdata_q(o_mem_rdata_q), .o_disp_hit_q(o_disp_hit_q), .o_gp_redirect_q(o_gp_redirect_q),
    .o_com_q(o_com_q), .o_seg_q(o_seg_q), .o_lcd_tick_q(o_lcd_tick_q), .o_pump_clk_q(o_pump_clk_q),
    .o_cfg_q(o_cfg_q));

// File: testbench/lcd_panel_model.sv
// Purpose: Segment panel seen on one segment column
// Assumes: One-hot commons, segment level sampled while common active
// Notes: Records which commons lit the element on column COL
`timescale 1ns/1ps
module lcd_panel_model #(
    parameter int DISP_WORDS = 46,
    parameter int COL = 3
) (
    // Clock and drive
    input wire logic i_mclk,
    input wire logic [7:0] i_com,
    input wire logic [DISP_WORDS-1:0] i_seg,
    input wire logic i_clear,
    // Lit map
    output logic [7:0] o_lit_q
);
    // ****************************************
    // Element state
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_clear) begin
            o_lit_q <= 8'h00;
        end else begin
            for (int k = 0; k < 8; k++) begin
                if (i_com[k]) begin
                    o_lit_q[k] <= i_seg[COL];
                end
            end
        end
    end
endmodule // lcd_panel_model

// File: testbench/segment_lcd_driver_control_bench.sv
// Purpose: Self-checking bench for the LCD driver control
// Assumes: Subclock sped up to a 2 us period to keep the run short
// Notes: Rates checked with one count of slack for synchroniser phase
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end
module segment_lcd_driver_control_bench;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic low_speed_rc_osc = 1'b0;
    logic low_speed_crystal_osc = 1'b0;
    logic lxt_run = 1'b0;
    logic src_sel = 1'b0;
    logic sleep_in = 1'b0;
    logic panel_clr = 1'b1;
    lcd_pkg::mem_req_type req = '0;
    logic [1:0] reg_sel = 2'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wd = 8'h00;
    logic [7:0] mem_rd, reg_rdq, com, lit;
    logic hit, redir, tick, pump, pol;
    logic [45:0] seg;
    lcd_pkg::analog_cfg_type cfg;
    int mismatches = 0;
    int total_checks = 0;
    int nt, np, nl;
    lcd_driver_control #(.DISP_WORDS(46)) i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_low_speed_rc_osc_clk(low_speed_rc_osc),
        .i_lxt_clk(low_speed_crystal_osc), .i_subclk_src_select(src_sel), .i_sleep(sleep_in), .i_mem_req(req),
        .o_mem_rdata_q(mem_rd), .o_disp_hit_q(hit), .o_gp_redirect_q(redir), .i_reg_sel(reg_sel),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wd), .o_reg_rdata_q(reg_rdq), .o_com_q(com),
        .o_seg_q(seg), .o_polarity_q(pol), .o_lcd_tick_q(tick), .o_pump_clk_q(pump), .o_cfg_q(cfg));
    lcd_panel_model #(.DISP_WORDS(46), .COL(3)) i_panel (.i_mclk(i_mclk), .i_com(com), .i_seg(seg),
        .i_clear(panel_clr), .o_lit_q(lit));
    initial forever #50 i_mclk = ~i_mclk;
    initial forever #1003 low_speed_rc_osc = ~low_speed_rc_osc;
    initial forever begin
        #997;
        if (lxt_run) low_speed_crystal_osc = ~low_speed_crystal_osc;
    end
    task automatic reg_w(input logic [1:0] s, input logic [7:0] d);
        @(posedge i_mclk);
        reg_sel <= s;
        reg_wd <= d;
        reg_wr <= 1'b1;
        @(posedge i_mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_chk(input logic [1:0] s, input logic [7:0] e);
        @(posedge i_mclk);
        reg_sel <= s;
        reg_rd <= 1'b1;
        @(posedge i_mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdq, e)
    endtask
    task automatic mem_chk(input logic [7:0] sec, off, input logic ind, w, input logic [7:0] wd,
            input logic eh, er, input logic [7:0] ed);
        @(posedge i_mclk);
        req <= '{sec, off, ind, w, !w, wd};
        @(posedge i_mclk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1;
        `CHK(hit, eh)
        `CHK(redir, er)
        if (!w) `CHK(mem_rd, ed)
    endtask
    task automatic count_ev(input int n);
        logic p;
        logic q;
        nt = 0;
        np = 0;
        nl = 0;
        p = pump;
        q = pol;
        repeat (n) begin
            @(posedge i_mclk);
            #1;
            nt += int'(tick);
            np += int'(pump && !p);
            nl += int'(pol != q);
            p = pump;
            q = pol;
        end
    endtask
    task automatic test_regs;
        reg_chk(lcd_pkg::SEL_MAIN, lcd_pkg::REG_RESET);
        reg_chk(lcd_pkg::SEL_DUTY, lcd_pkg::REG_RESET);
        reg_w(lcd_pkg::SEL_MAIN, 8'hBE);
        reg_w(lcd_pkg::SEL_PUMP, 8'hFF);
        reg_w(lcd_pkg::SEL_DUTY, 8'hFF);
        reg_w(2'h3, 8'hFF);
        reg_chk(lcd_pkg::SEL_MAIN, 8'hB6);
        reg_chk(lcd_pkg::SEL_PUMP, 8'h0B);
        reg_chk(lcd_pkg::SEL_DUTY, 8'hE7);
        reg_chk(2'h3, 8'h00);
        `CHK(cfg, 12'hBDF)
        reg_w(lcd_pkg::SEL_MAIN, 8'h01);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK(cfg.res_pump_on, 1'b1)
        // Power select must be clear before capacitor bias
        reg_w(lcd_pkg::SEL_PUMP, 8'h03);
        reg_w(lcd_pkg::SEL_MAIN, 8'h41);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK({cfg.cap_bias, cfg.res_pump_on}, 2'b10)
        reg_w(lcd_pkg::SEL_MAIN, 8'h00);
        reg_w(lcd_pkg::SEL_PUMP, 8'h00);
        reg_w(lcd_pkg::SEL_DUTY, 8'h00);
        $display("test regs done");
    endtask
    task automatic test_memory;
        mem_chk(8'h04, 8'h03, 1, 1, 8'hFF, 1, 0, 8'h00);
        mem_chk(8'h04, 8'h03, 1, 0, 8'h00, 1, 0, 8'h0F);
        mem_chk(8'h04, 8'h2D, 1, 1, 8'hA5, 1, 0, 8'h00);
        mem_chk(8'h04, 8'h2D, 1, 0, 8'h00, 1, 0, 8'h05);
        mem_chk(8'h04, 8'h2E, 1, 1, 8'hFF, 0, 0, 8'h00);
        mem_chk(8'h00, 8'h03, 1, 1, 8'h00, 0, 0, 8'h00);
        mem_chk(8'h04, 8'h03, 0, 1, 8'h00, 0, 1, 8'h00);
        mem_chk(8'h04, 8'h03, 1, 0, 8'h00, 1, 0, 8'h0F);
        reg_w(lcd_pkg::SEL_DUTY, 8'h04);
        mem_chk(8'h04, 8'h03, 1, 1, 8'hA5, 1, 0, 8'h00);
        mem_chk(8'h04, 8'h03, 1, 0, 8'h00, 1, 0, 8'hA5);
        reg_w(lcd_pkg::SEL_DUTY, 8'h00);
        mem_chk(8'h04, 8'h03, 1, 0, 8'h00, 1, 0, 8'h05);
        $display("test memory done");
    endtask
    task automatic test_scan;
        reg_w(lcd_pkg::SEL_MAIN, 8'h01);
        panel_clr <= 1'b0;
        repeat (1700) @(posedge i_mclk);
        #1;
        `CHK(lit, 8'h05)
        `CHK(com[7:4], 4'h0)
        panel_clr <= 1'b1;
        reg_w(lcd_pkg::SEL_MAIN, 8'h81);
        panel_clr <= 1'b0;
        repeat (900) @(posedge i_mclk);
        #1;
        `CHK(lit, 8'h05)
        @(posedge i_mclk);
        sleep_in <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK({com, seg, pol}, 55'h0)
        @(posedge i_mclk);
        sleep_in <= 1'b0;
        repeat (400) @(posedge i_mclk);
        #1;
        `CHK(com != 8'h00, 1'b1)
        reg_w(lcd_pkg::SEL_MAIN, 8'h00);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK(com, 8'h00)
        $display("test scan done");
    endtask
    task automatic test_clocks;
        reg_w(lcd_pkg::SEL_MAIN, 8'h01);
        count_ev(1280);
        `CHK(nt inside {[7:9]}, 1'b1)
        `CHK(nl inside {[nt - 1:nt + 1]}, 1'b1)
        @(posedge i_mclk);
        src_sel <= 1'b1;
        count_ev(40);
        count_ev(1280);
        `CHK(nt == 0, 1'b1)
        lxt_run <= 1'b1;
        count_ev(1280);
        `CHK(nt inside {[7:9]}, 1'b1)
        @(posedge i_mclk);
        src_sel <= 1'b0;
        lxt_run <= 1'b0;
        $display("test clocks done");
    endtask
    task automatic test_pump;
        int e;
        reg_w(lcd_pkg::SEL_MAIN, 8'h41);
        for (int c = 3; c < 8; c++) begin
            e = (c == 7) ? 16 : (1 << (c - 2));
            reg_w(lcd_pkg::SEL_DUTY, {3'(c), 5'h00});
            count_ev(640);
            `CHK(np inside {[e - 1:e + 1]}, 1'b1)
        end
        reg_w(lcd_pkg::SEL_MAIN, 8'h00);
        $display("test pump done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bound well above the expected 10k cycles
    initial begin
        #4_000_000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        test_regs();
        test_memory();
        test_scan();
        test_clocks();
        test_pump();
        complete_run();
    end
endmodule // segment_lcd_driver_control_bench
